// ---- tpcu_timer.v ----
// Timer unit with prescaled 16-bit counter, capture/compare/PWM channels and Avalon-MM slave
`timescale 1ns/1ps
`include "tpcu_regs.vh"

// Notes on behaviour
// - The counter clock goes through a prescaler dividing by 1, 2, 4, 8, 16, 32, 64 or 128.
// - The 16-bit counter counts either freely upward or up and down, the latter for center-aligned PWM.
// - A 16-bit modulus register limits the range over which the counter counts.
// - Each channel has its own interrupt source and the unit raises a terminal-count interrupt per range.
// - Each channel is set on its own to input capture, output compare or buffered edge-aligned PWM.
// - Capture triggers on a selectable rising edge, falling edge or either edge of the channel input.
// - A compare match sets, clears or toggles the channel output as selected per channel.
// - Output polarity of each channel is selectable whenever it generates PWM.
// - The unit supports buffered center-aligned PWM on all of its channels at once.
// - With comparator routing on, the analog comparator output is the input of capture channel 0.
// - With comparator routing on, the channel 0 pin is never driven, whatever the timer setup.
// - Clock-source select at 1:1 makes the external timer clock pin the counter clock.
// - The external timer clock can clock the modulo timer and this timer at the same time.
// - Each instance has its own clock-source selection, independent of any other instance.
// - The channel count is a per-instance parameter, one or two channels.

module tpcu_timer #(
	parameter NUM_CH = 2
) (
	input  wire                clk_in,
	input  wire                arst_n_in,
	input  wire                ce_in,
	input  wire [5:0]          avs_address_in,
	input  wire                avs_read_in,
	input  wire                avs_write_in,
	input  wire [31:0]         avs_writedata_in,
	input  wire [3:0]          avs_byteenable_in,
	output reg  [31:0]         avs_readdata_out,
	output wire                avs_waitrequest_out,
	output wire                irq_out,
	input  wire                external_timer_clock_pin_in,
	input  wire                analog_comparator_in,
	input  wire [NUM_CH-1:0]   ch_pin_in,
	output wire [NUM_CH-1:0]   ch_pin_out,
	output wire [NUM_CH-1:0]   ch_pin_oe_out,
	output reg                 modulo_timer_clock_out
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function [15:0] merge16;
		input [15:0] old_val;
		input [31:0] wdata;
		input [3:0]  be;
		begin
			merge16 = {be[1] ? wdata[15:8] : old_val[15:8], be[0] ? wdata[7:0] : old_val[7:0]};
		end
	endfunction

	// Mode field of a channel control word
	function [1:0] mode_of;
		input [`TPCU_CC_W-1:0] ctrl;
		begin
			mode_of = ctrl[`TPCU_CC_MODE_LSB +: 2];
		end
	endfunction

	// Channel register write select, shared by the value and control paths
	function ch_wr;
		input [2:0] sel;
		input       is_value;
		input       idx;
		begin
			ch_wr = sel[2] & (sel[1] == is_value) & (sel[0] == idx);
		end
	endfunction

	// Channel register hit: returns {hit, is_value, channel}
	function [2:0] ch_decode;
		input [5:0] addr;
		begin
			ch_decode = 3'h0;
			if (addr[5:4] == `TPCU_OFF_CH_BASE >> 4 && addr[3:`TPCU_CH_STRIDE_LOG2] < NUM_CH && addr[1:0] == 2'h0) begin
				ch_decode = {1'b1, addr[2], addr[3]};
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg  [`TPCU_SC_W-1:0]  status_control;
	reg  [15:0]            modulus;
	reg  [15:0]            count;
	reg                    count_down;
	reg  [6:0]             presc;
	reg  [`TPCU_STS_W-1:0] int_status;
	reg  [`TPCU_STS_W-1:0] int_mask;
	reg                    comparator_capture_route;
	reg  [`TPCU_CC_W-1:0]  ch_ctrl   [0:`TPCU_MAX_CH-1];
	reg  [15:0]            val_buf   [0:`TPCU_MAX_CH-1];
	reg  [15:0]            val_act   [0:`TPCU_MAX_CH-1];
	reg  [`TPCU_MAX_CH-1:0] ch_out;
	reg  [`TPCU_MAX_CH-1:0] cap_prev;
	reg                    ack;
	reg  [1:0]             ext_sync;
	reg                    ext_prev;
	reg  [1:0]             cmp_sync;
	reg  [15:0]            next_count;
	reg                    next_count_down;
	reg  [31:0]            next_readdata;

	wire [`TPCU_MAX_CH-1:0] cap_in;
	wire [`TPCU_MAX_CH-1:0] cap_hit;
	wire [`TPCU_MAX_CH-1:0] cmp_hit;
	wire [`TPCU_MAX_CH-1:0] oe_all;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// One wait cycle per access gives read data a full cycle to settle
	wire       access  = avs_read_in | avs_write_in;
	wire       wr_en   = avs_write_in & ack;
	wire [2:0] ch_sel  = ch_decode(avs_address_in);
	assign avs_waitrequest_out = access & ~ack;

	// Read data is captured in the wait cycle and held until the next access
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack              <= 1'b0;
			avs_readdata_out <= 32'h0000_0000;
		end else if (ce_in) begin
			ack <= access & ~ack;
			if (access & ~ack) begin
				avs_readdata_out <= next_readdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Only the second stage is read, so a metastable first stage never reaches logic
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ext_sync <= 2'h0;
			cmp_sync <= 2'h0;
		end else if (ce_in) begin
			ext_sync <= {ext_sync[0], external_timer_clock_pin_in};
			cmp_sync <= {cmp_sync[0], analog_comparator_in};
		end
	end

	// ----------------------------------------------------------------
	// Clock source and prescaler
	// ----------------------------------------------------------------
	wire [1:0] clock_source_select = status_control[`TPCU_SC_CLKSEL_LSB +: 2];
	wire [2:0] presc_sel   = status_control[`TPCU_SC_PRESC_LSB +: 3];
	wire       center_aligned_mode = status_control[`TPCU_SC_CENTER_BIT];
	wire       ext_rise    = ext_sync[1] & ~ext_prev;
	wire       src_tick    = (clock_source_select == `TPCU_CLK_BUS) |
	                         ((clock_source_select == `TPCU_CLK_EXT) & ext_rise);
	wire [6:0] presc_mask  = `TPCU_PRESC_ALL >> (3'd7 - presc_sel);
	wire       cnt_tick    = src_tick & ((presc & presc_mask) == presc_mask);
	// Zero modulus keeps the full range, so with the modulus unset the counter still counts
	wire [15:0] top        = (modulus == 16'h0000) ? `TPCU_FULL_RANGE : modulus;
	wire       boundary    = cnt_tick & (next_count == 16'h0000) & (count != 16'h0000);

	// ----------------------------------------------------------------
	// Counter next state
	// ----------------------------------------------------------------
	always @* begin
		next_count      = count;
		next_count_down = count_down;
		if (cnt_tick) begin
			if (center_aligned_mode) begin
				if (!count_down) begin
					if (count >= top) begin
						next_count_down = 1'b1;
						next_count      = count - 16'h0001;
					end else begin
						next_count = count + 16'h0001;
					end
				end else if (count <= 16'h0001) begin
					next_count      = 16'h0000;
					next_count_down = 1'b0;
				end else begin
					next_count = count - 16'h0001;
				end
			end else begin
				next_count_down = 1'b0;
				next_count      = (count >= top) ? 16'h0000 : count + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel inputs and pins
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `TPCU_MAX_CH; gi = gi + 1) begin : g_ch
			if (gi < NUM_CH) begin : g_on
				reg [1:0] pin_sync;
				wire [1:0] mode = mode_of(ch_ctrl[gi]);
				wire [1:0] edge_sel = ch_ctrl[gi][`TPCU_CC_EDGE_LSB +: 2];
				always @(posedge clk_in or negedge arst_n_in) begin
					if (!arst_n_in) begin
						pin_sync <= 2'h0;
					end else if (ce_in) begin
						pin_sync <= {pin_sync[0], ch_pin_in[gi]};
					end
				end
				if (gi == 0) begin : g_route
					assign cap_in[gi] = comparator_capture_route ? cmp_sync[1] : pin_sync[1];
				end else begin : g_pin
					assign cap_in[gi] = pin_sync[1];
				end
				assign cap_hit[gi] = (mode == `TPCU_MODE_CAPTURE) &
				                     ((edge_sel[0] & cap_in[gi] & ~cap_prev[gi]) |
				                      (edge_sel[1] & ~cap_in[gi] & cap_prev[gi]));
				assign cmp_hit[gi] = cnt_tick & (count == val_act[gi]) &
				                     ((mode == `TPCU_MODE_COMPARE) | (mode == `TPCU_MODE_PWM));
				assign oe_all[gi]  = ((mode == `TPCU_MODE_PWM) |
				                      ((mode == `TPCU_MODE_COMPARE) & (ch_ctrl[gi][`TPCU_CC_ACT_LSB +: 2] != `TPCU_ACT_NONE))) &
				                     ~((gi == 0) & comparator_capture_route);
				assign ch_pin_out[gi]    = ch_out[gi];
				assign ch_pin_oe_out[gi] = oe_all[gi];
			end else begin : g_off
				assign cap_in[gi]  = 1'b0;
				assign cap_hit[gi] = 1'b0;
				assign cmp_hit[gi] = 1'b0;
				assign oe_all[gi]  = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Interrupt
	// ----------------------------------------------------------------
	wire [`TPCU_STS_W-1:0] evt = {cmp_hit | cap_hit, boundary};
	assign irq_out = |(int_status & int_mask);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always @* begin
		next_readdata = 32'h0000_0000;
		if (ch_sel[2]) begin
			if (ch_sel[1]) begin
				next_readdata[15:0] = val_buf[ch_sel[0]];
			end else begin
				next_readdata[`TPCU_CC_W-1:0] = ch_ctrl[ch_sel[0]];
			end
		end else begin
			case (avs_address_in)
				`TPCU_OFF_STATUS_CONTROL: next_readdata[`TPCU_SC_W-1:0]  = status_control;
				`TPCU_OFF_COUNT:          next_readdata[15:0]             = count;
				`TPCU_OFF_MODULUS:        next_readdata[15:0]             = modulus;
				`TPCU_OFF_INT_STATUS:     next_readdata[`TPCU_STS_W-1:0] = int_status;
				`TPCU_OFF_INT_MASK:       next_readdata[`TPCU_STS_W-1:0] = int_mask;
				`TPCU_OFF_OPTION:         next_readdata[`TPCU_OPT_ROUTE_BIT] = comparator_capture_route;
				default:                  next_readdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Main sequential logic
	// ----------------------------------------------------------------
	integer i;
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			status_control           <= `TPCU_RST_SC;
			modulus                  <= `TPCU_RST_MODULUS;
			count                    <= 16'h0000;
			count_down               <= 1'b0;
			presc                    <= 7'h00;
			int_status               <= {`TPCU_STS_W{1'b0}};
			int_mask                 <= {`TPCU_STS_W{1'b0}};
			comparator_capture_route <= 1'b0;
			ext_prev                 <= 1'b0;
			modulo_timer_clock_out   <= 1'b0;
			ch_out                   <= {`TPCU_MAX_CH{1'b0}};
			cap_prev                 <= {`TPCU_MAX_CH{1'b0}};
			for (i = 0; i < `TPCU_MAX_CH; i = i + 1) begin
				ch_ctrl[i] <= `TPCU_RST_CC;
				val_buf[i] <= `TPCU_RST_VALUE;
				val_act[i] <= `TPCU_RST_VALUE;
			end
		end else if (ce_in) begin
			ext_prev <= ext_sync[1];
			cap_prev <= cap_in;
			// Same synchronised edge feeds the modulo timer, whatever this unit selects
			modulo_timer_clock_out <= ext_rise;

			if (src_tick) begin
				presc <= presc + 7'h01;
			end
			count      <= next_count;
			count_down <= next_count_down;

			// A new event wins over a write-one-to-clear in the same cycle
			int_status <= (int_status & ~((wr_en && avs_address_in == `TPCU_OFF_INT_STATUS) ?
			              avs_writedata_in[`TPCU_STS_W-1:0] : {`TPCU_STS_W{1'b0}})) | evt;

			for (i = 0; i < `TPCU_MAX_CH; i = i + 1) begin
				if (i < NUM_CH) begin
					case (mode_of(ch_ctrl[i]))
						`TPCU_MODE_COMPARE: begin
							val_act[i] <= val_buf[i];
							if (cmp_hit[i]) begin
								case (ch_ctrl[i][`TPCU_CC_ACT_LSB +: 2])
									`TPCU_ACT_TOGGLE: ch_out[i] <= ~ch_out[i];
									`TPCU_ACT_CLEAR:  ch_out[i] <= 1'b0;
									`TPCU_ACT_SET:    ch_out[i] <= 1'b1;
									default:          ch_out[i] <= ch_out[i];
								endcase
							end
						end
						`TPCU_MODE_PWM: begin
							// Buffered duty loads only at a period end to avoid runt pulses
							if (boundary) begin
								val_act[i] <= val_buf[i];
							end
							ch_out[i] <= (next_count < val_act[i]) ^ ch_ctrl[i][`TPCU_CC_POL_BIT];
						end
						default: begin
							val_act[i] <= val_buf[i];
							ch_out[i]  <= 1'b0;
						end
					endcase
					if (cap_hit[i]) begin
						val_buf[i] <= count;
					end else if (wr_en && ch_wr(ch_sel, 1'b1, i[0])) begin
						val_buf[i] <= merge16(val_buf[i], avs_writedata_in, avs_byteenable_in);
					end
					if (wr_en && ch_wr(ch_sel, 1'b0, i[0]) && avs_byteenable_in[0]) begin
						ch_ctrl[i] <= avs_writedata_in[`TPCU_CC_W-1:0];
					end
				end
			end

			if (wr_en && !ch_sel[2]) begin
				case (avs_address_in)
					`TPCU_OFF_STATUS_CONTROL: begin
						if (avs_byteenable_in[0]) begin
							status_control <= avs_writedata_in[`TPCU_SC_W-1:0];
						end
					end
					`TPCU_OFF_COUNT: begin
						// Any write restarts the count and prescaler
						count      <= 16'h0000;
						count_down <= 1'b0;
						presc      <= 7'h00;
					end
					`TPCU_OFF_MODULUS:  modulus <= merge16(modulus, avs_writedata_in, avs_byteenable_in);
					`TPCU_OFF_INT_MASK: begin
						if (avs_byteenable_in[0]) begin
							int_mask <= avs_writedata_in[`TPCU_STS_W-1:0];
						end
					end
					`TPCU_OFF_OPTION: begin
						if (avs_byteenable_in[0]) begin
							comparator_capture_route <= avs_writedata_in[`TPCU_OPT_ROUTE_BIT];
						end
					end
					default: begin
						modulus <= modulus;
					end
				endcase
			end
		end
	end

endmodule // tpcu_timer

// ---- tpcu_regs.vh ----
// Register map, field positions, encodings and reset values of the timer unit
`ifndef TPCU_REGS_VH
`define TPCU_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TPCU_OFF_STATUS_CONTROL 6'h00
`define TPCU_OFF_COUNT          6'h04
`define TPCU_OFF_MODULUS        6'h08
`define TPCU_OFF_INT_STATUS     6'h0C
`define TPCU_OFF_INT_MASK       6'h10
`define TPCU_OFF_OPTION         6'h14
`define TPCU_OFF_CH_BASE        6'h20
`define TPCU_CH_STRIDE_LOG2     3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TPCU_SC_PRESC_LSB       0
`define TPCU_SC_CLKSEL_LSB      3
`define TPCU_SC_CENTER_BIT      5
`define TPCU_SC_W               6
`define TPCU_OPT_ROUTE_BIT      0
`define TPCU_CC_MODE_LSB        0
`define TPCU_CC_EDGE_LSB        2
`define TPCU_CC_ACT_LSB         4
`define TPCU_CC_POL_BIT         6
`define TPCU_CC_W               7
`define TPCU_STS_TC_BIT         0
`define TPCU_STS_W              3
`define TPCU_MAX_CH             2

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define TPCU_CLK_OFF            2'h0
`define TPCU_CLK_BUS            2'h1
`define TPCU_CLK_EXT            2'h3
`define TPCU_MODE_OFF           2'h0
`define TPCU_MODE_CAPTURE       2'h1
`define TPCU_MODE_COMPARE       2'h2
`define TPCU_MODE_PWM           2'h3
`define TPCU_ACT_NONE           2'h0
`define TPCU_ACT_TOGGLE         2'h1
`define TPCU_ACT_CLEAR          2'h2
`define TPCU_ACT_SET            2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TPCU_RST_SC             6'h00
`define TPCU_RST_MODULUS        16'h0000
`define TPCU_RST_CC             7'h00
`define TPCU_RST_VALUE          16'h0000
`define TPCU_FULL_RANGE         16'hFFFF
`define TPCU_PRESC_ALL          7'h7F

`endif

// ---- tpcu_timer_chk.sv ----
// Port-level checker of the timer unit, bound to every instance
`timescale 1ns/1ps
module tpcu_timer_chk #(
	parameter NUM_CH = 2
) (
	input wire              clk_in,
	input wire              arst_n_in,
	input wire              ce_in,
	input wire [5:0]        avs_address_in,
	input wire              avs_read_in,
	input wire              avs_write_in,
	input wire [31:0]       avs_writedata_in,
	input wire [3:0]        avs_byteenable_in,
	input wire [31:0]       avs_readdata_out,
	input wire              avs_waitrequest_out,
	input wire              irq_out,
	input wire              external_timer_clock_pin_in,
	input wire              analog_comparator_in,
	input wire [NUM_CH-1:0] ch_pin_in,
	input wire [NUM_CH-1:0] ch_pin_out,
	input wire [NUM_CH-1:0] ch_pin_oe_out,
	input wire              modulo_timer_clock_out
);
	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	wire req = avs_read_in | avs_write_in;
	reg  route;
	// Shadow of the routing bit, since the checker sees only ports
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			route <= 1'b0;
		else if (ce_in && avs_write_in && !avs_waitrequest_out && avs_address_in == 6'h14 && avs_byteenable_in[0])
			route <= avs_writedata_in[0];
	end
	sequence s_wr_done(logic [5:0] a);
		avs_write_in && !avs_waitrequest_out && ce_in && avs_byteenable_in[0] && avs_address_in == a;
	endsequence
	sequence s_wait_start;
		req && avs_waitrequest_out && ce_in;
	endsequence
	a_wait_idle: assert property (!req |-> !avs_waitrequest_out) else $error("waitrequest without request");
	a_wait_once: assert property (s_wait_start |=> !avs_waitrequest_out) else $error("more than one wait state");
	a_read_upper: assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_rdata_hold: assert property (!req |=> $stable(avs_readdata_out)) else $error("read data changed while idle");
	a_route_oe: assert property (route |-> !ch_pin_oe_out[0]) else $error("channel 0 pin driven while routed");
	a_mask_quiet: assert property (s_wr_done(6'h10) ##0 avs_writedata_in[2:0] == 3'h0 |=> !irq_out)
		else $error("interrupt high with all masked");
	a_modclk_pulse: assert property (modulo_timer_clock_out |=> !modulo_timer_clock_out)
		else $error("modulo timer clock pulse too long");
	a_modclk_follow: assert property ($rose(external_timer_clock_pin_in) |-> ##[1:5] modulo_timer_clock_out)
		else $error("modulo timer clock missed an edge");
endmodule // tpcu_timer_chk

bind tpcu_timer tpcu_timer_chk #(.NUM_CH(NUM_CH)) u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
	.external_timer_clock_pin_in(external_timer_clock_pin_in), .analog_comparator_in(analog_comparator_in),
	.ch_pin_oe_out(ch_pin_oe_out), .modulo_timer_clock_out(modulo_timer_clock_out));

// ---- tpcu_far_side.sv ----
// Model of the channel pins, external clock pin and comparator around the timer
`timescale 1ns/1ps
module tpcu_far_side (
	input  wire       clk_in,
	input  wire [1:0] pin_out_in,
	input  wire [1:0] pin_oe_in,
	output reg        ext_clk_out = 1'b0,
	output reg        cmp_out = 1'b0,
	output wire [1:0] pin_level_out
);
	// ------------------------------------------------
	// Pin resolution and stimulus
	// ------------------------------------------------
	reg [1:0] drive = 2'h0;
	// The timer wins the wire while it drives, the outside source otherwise
	assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drive);
	// Slow pulses so that each edge survives the input synchroniser
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge clk_in);
			ext_clk_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			ext_clk_out <= 1'b0;
			repeat (3) @(posedge clk_in);
		end
	endtask
	task automatic set_pin(input int i, input logic v);
		@(posedge clk_in);
		drive[i] <= v;
	endtask
	task automatic set_cmp(input logic v);
		@(posedge clk_in);
		cmp_out <= v;
	endtask
endmodule // tpcu_far_side

// ---- tb_timer_pwm_capture_unit.sv ----
// Self-checking testbench of the timer unit
`timescale 1ns/1ps
module tb_timer_pwm_capture_unit;
	// ------------------------------------------------
	// Bench
	// ------------------------------------------------
	logic        clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [5:0]  avs_address_in = 6'h00;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] q, c;
	wire  [31:0] avs_readdata_out;
	wire         avs_waitrequest_out, irq_out, ext_clk, cmp, mod_clk;
	wire  [1:0]  pin_in, pin_out, pin_oe;
	int          err_total = 0;
	int          cmp_count = 0;
	int          mod_seen = 0;
	int          n, k;
	tpcu_timer #(.NUM_CH(2)) uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .external_timer_clock_pin_in(ext_clk),
		.analog_comparator_in(cmp), .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe_out(pin_oe),
		.modulo_timer_clock_out(mod_clk));
	tpcu_far_side far (.clk_in(clk_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_clk_out(ext_clk),
		.cmp_out(cmp), .pin_level_out(pin_in));
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (mod_clk === 1'b1)
			mod_seen++;
	end
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		// Only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge clk_in);
		end while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk_reg(q, exp);
	endtask
	// High cycles of a channel pin; windows are whole periods so phase drops out
	task automatic hi_cnt(input int ch, input int cyc);
		n = 0;
		repeat (cyc) begin
			@(negedge clk_in);
			if (pin_out[ch] === 1'b1)
				n++;
		end
	endtask
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#1000000;
		err_total++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge clk_in);
		arst_n_in <= 1'b1;
		rdc(6'h00, 32'h0);
		rdc(6'h08, 32'h0);
		rdc(6'h20, 32'h0);
		bus(1'b1, 6'h18, 32'hFFFF);
		rdc(6'h18, 32'h0);
		for (k = 0; k < 8; k++) begin
			bus(1'b1, 6'h00, 32'h08 | k);
			bus(1'b0, 6'h04, 32'h0);
			c = q;
			repeat (253) @(posedge clk_in);
			bus(1'b0, 6'h04, 32'h0);
			chk_reg((q - c) & 32'hFFFF, 256 >> k);
		end
		bus(1'b1, 6'h00, 32'h18);
		bus(1'b0, 6'h04, 32'h0);
		c = q;
		k = mod_seen;
		far.ext_pulses(10);
		repeat (6) @(posedge clk_in);
		bus(1'b0, 6'h04, 32'h0);
		chk_reg((q - c) & 32'hFFFF, 10);
		chk_reg(mod_seen - k, 10);
		bus(1'b1, 6'h08, 32'h9);
		bus(1'b1, 6'h00, 32'h08);
		bus(1'b1, 6'h0C, 32'h7);
		bus(1'b1, 6'h10, 32'h1);
		repeat (12) @(posedge clk_in);
		rdc(6'h0C, 32'h1);
		chk_reg(irq_out, 1);
		for (k = 0; k < 8; k++) begin
			bus(1'b0, 6'h04, 32'h0);
			chk_reg(q < 10, 1);
		end
		bus(1'b1, 6'h10, 32'h0);
		@(negedge clk_in);
		chk_reg(irq_out, 0);
		bus(1'b1, 6'h24, 32'h4);
		bus(1'b1, 6'h20, 32'h03);
		repeat (25) @(posedge clk_in);
		hi_cnt(0, 200);
		chk_reg(n, 80);
		bus(1'b1, 6'h20, 32'h43);
		repeat (25) @(posedge clk_in);
		hi_cnt(0, 200);
		chk_reg(n, 120);
		bus(1'b1, 6'h08, 32'hA);
		bus(1'b1, 6'h2C, 32'h6);
		bus(1'b1, 6'h28, 32'h03);
		bus(1'b1, 6'h20, 32'h03);
		bus(1'b1, 6'h00, 32'h28);
		repeat (45) @(posedge clk_in);
		hi_cnt(0, 200);
		chk_reg(n, 70);
		hi_cnt(1, 200);
		chk_reg(n, 110);
		bus(1'b1, 6'h28, 32'h0);
		bus(1'b1, 6'h08, 32'h9);
		bus(1'b1, 6'h00, 32'h08);
		bus(1'b1, 6'h20, 32'h32);
		bus(1'b1, 6'h24, 32'h5);
		repeat (15) @(posedge clk_in);
		chk_reg(pin_out[0], 1);
		chk_reg(pin_oe[0], 1);
		bus(1'b1, 6'h20, 32'h22);
		repeat (15) @(posedge clk_in);
		chk_reg(pin_out[0], 0);
		bus(1'b1, 6'h20, 32'h12);
		repeat (5) @(posedge clk_in);
		hi_cnt(0, 200);
		chk_reg(n, 100);
		bus(1'b1, 6'h00, 32'h0);
		bus(1'b1, 6'h20, 32'h0);
		rdc(6'h0C, 32'h7);
		bus(1'b1, 6'h0C, 32'h7);
		rdc(6'h0C, 32'h0);
		bus(1'b1, 6'h24, 32'hABCD);
		bus(1'b0, 6'h04, 32'h0);
		c = q;
		for (k = 1; k < 4; k++) begin
			bus(1'b1, 6'h20, (k << 2) | 1);
			bus(1'b1, 6'h0C, 32'h7);
			far.set_pin(0, 1'b1);
			repeat (6) @(posedge clk_in);
			rdc(6'h0C, (k & 1) << 1);
			bus(1'b1, 6'h0C, 32'h7);
			far.set_pin(0, 1'b0);
			repeat (6) @(posedge clk_in);
			rdc(6'h0C, k & 2);
		end
		rdc(6'h24, c);
		bus(1'b1, 6'h14, 32'h1);
		bus(1'b1, 6'h20, 32'h05);
		bus(1'b1, 6'h0C, 32'h7);
		far.set_pin(0, 1'b1);
		repeat (6) @(posedge clk_in);
		rdc(6'h0C, 32'h0);
		far.set_cmp(1'b1);
		repeat (6) @(posedge clk_in);
		rdc(6'h0C, 32'h2);
		bus(1'b1, 6'h20, 32'h32);
		@(negedge clk_in);
		chk_reg(pin_oe[0], 0);
		end_of_test;
	end
endmodule // tb_timer_pwm_capture_unit
